// ==== logic/touch_ctrl_pkg.sv ====
/*
 Package for the touch measurement state control block: register offsets,
 field positions, reset values, state encodings and timing counts.
 Assumes a 100 MHz core clock and a plain strobe register port.
*/
`default_nettype none
package touch_ctrl_pkg;
    localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_SENSE = 4'h3;
    localparam int START_POS = 0;
    localparam int TRIG_SEL_POS = 1;
    localparam int SUSPEND_POS = 2;
    localparam int INIT_POS = 4;
    localparam int POWER_POS = 0;
    localparam logic [7:0] CONTROL_ZERO_RESET = 8'h00;
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] STATE_IDLE_CODE = 3'h0;
    localparam logic [2:0] STATE_CHARGE_CODE = 3'h1;
    localparam logic [2:0] STATE_COUNT_CODE = 3'h2;
    localparam logic [2:0] STATE_DONE_CODE = 3'h3;
    localparam int MEASURE_CYCLES = 32;
    localparam int SNZ_SETTLE_BASE_CYCLES = 64;
    typedef enum logic [2:0] {
        ST_STOPPED,
        ST_WAIT_START,
        ST_MEASURE,
        ST_PREP_TRIG,
        ST_SUSP_TRIG,
        ST_SW_SUSP
    } unit_state_t;
endpackage
`default_nettype wire

// ==== logic/touch_measure_state_control.sv ====
/*
 Touch measurement state control: control registers, operating state machine,
 measurement supply and filter capacitor charge control, STOP-mode wake.
 Assumes a strobe register port on the core clock, an asynchronous interval
 timer trigger and an asynchronous CPU STOP indication.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_measure_state_control (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic interval_trigger_in,
    input wire logic cpu_stop_in,
    output logic [7:0] reg_rdata_out,
    output logic measurement_supply_out,
    output logic filter_charge_out,
    output logic clock_request_out,
    output logic measure_done_out,
    output touch_ctrl_pkg::unit_state_t unit_state_out
);
    import touch_ctrl_pkg::*;

    localparam logic [5:0] MEASURE_LAST = 6'(MEASURE_CYCLES - 1);

    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_b;
    logic trig_level;
    logic trig_rise;
    logic stop_level;
    logic stop_rise_unused;

    logic start_q, start_d;
    logic trig_sel_q, trig_sel_d;
    logic suspend_q, suspend_d;
    logic power_q, power_d;
    logic [2:0] meas_state_q, meas_state_d;
    logic [5:0] count_q, count_d;
    unit_state_t state_q, state_d;
    logic [7:0] rdata_q, rdata_d;
    logic supply_q, supply_d;
    logic charge_q, charge_d;
    logic clkreq_q, clkreq_d;
    logic done_q, done_d;
    logic wr_zero;
    logic start_write;
    logic init_write;
    logic measuring;
    logic run_ok;

    // Reset release through two flops keeps the release glitch-free.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_b = rst_sync2_q;

    // Trigger edge and STOP level come from other domains.
    touch_sync_edge u_trig_sync (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b),
        .async_in(interval_trigger_in),
        .level_out(trig_level),
        .rise_out(trig_rise)
    );
    touch_sync_edge u_stop_sync (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b),
        .async_in(cpu_stop_in),
        .level_out(stop_level),
        .rise_out(stop_rise_unused)
    );

    // Decode of a register write at a given offset, used for both controls.
    function automatic logic wr_hit(input logic [3:0] addr, input logic [3:0] target, input logic wr);
        wr_hit = wr && (addr == target);
    endfunction

    assign wr_zero = wr_hit(reg_addr_in, ADDR_CONTROL_ZERO, reg_write_in);
    assign start_write = wr_zero && reg_wdata_in[START_POS];
    assign init_write = wr_zero && reg_wdata_in[INIT_POS];
    assign measuring = (state_q == ST_MEASURE);
    // Only the two listed running combinations may run; a prohibited one falls to stopped.
    assign run_ok = power_d && !init_write && start_d && (trig_sel_d == suspend_d);

    // Control bits; completion clears start only on the software trigger path.
    always_comb begin
        start_d = start_q;
        trig_sel_d = trig_sel_q;
        suspend_d = suspend_q;
        power_d = power_q;
        if (wr_zero) begin
            trig_sel_d = reg_wdata_in[TRIG_SEL_POS];
            suspend_d = reg_wdata_in[SUSPEND_POS];
            if (start_write) begin
                start_d = 1'b1;
            end else begin
                start_d = 1'b0;
            end
        end else if (measuring && (count_q == MEASURE_LAST) && !trig_sel_q) begin
            start_d = 1'b0;
        end
        if (wr_hit(reg_addr_in, ADDR_CONTROL_ONE, reg_write_in)) begin
            power_d = reg_wdata_in[POWER_POS];
        end
    end

    // Operating state from the programmed combination and the trigger.
    always_comb begin
        state_d = ST_STOPPED;
        count_d = 6'h0;
        done_d = 1'b0;
        if (!run_ok) begin
            if (power_d && !init_write && suspend_d && !start_d && trig_sel_d) begin
                state_d = ST_PREP_TRIG;
            end else if (power_d && !init_write && suspend_d && !start_d && !trig_sel_d) begin
                state_d = ST_SW_SUSP;
            end else if (power_d && !init_write && !suspend_d && !start_d && !trig_sel_d) begin
                state_d = ST_WAIT_START;
            end
            if (measuring && !init_write && (count_q == MEASURE_LAST)) begin
                done_d = 1'b1;
            end
        end else if (measuring) begin
            if (count_q == MEASURE_LAST) begin
                done_d = 1'b1;
                state_d = trig_sel_q ? ST_SUSP_TRIG : ST_WAIT_START;
            end else begin
                state_d = ST_MEASURE;
                count_d = count_q + 6'h1;
            end
        end else if (trig_sel_d) begin
            // Suspension wait survives CPU STOP; a rise wakes the unit.
            state_d = trig_rise ? ST_MEASURE : ST_SUSP_TRIG;
        end else begin
            state_d = ST_MEASURE;
        end
    end

    // Status field follows the measurement phase; init clears it.
    always_comb begin
        meas_state_d = STATE_IDLE_CODE;
        if (init_write) begin
            meas_state_d = STATUS_RESET[2:0];
        end else if (state_d == ST_MEASURE) begin
            meas_state_d = (count_d < 6'h8) ? STATE_CHARGE_CODE : STATE_COUNT_CODE;
        end
    end

    // Pin-side outputs: supply and filter charge off in suspended states.
    always_comb begin
        supply_d = (state_d == ST_WAIT_START) || (state_d == ST_MEASURE);
        charge_d = supply_d;
        clkreq_d = (state_d == ST_MEASURE) && stop_level;
        rdata_d = 8'h00;
        if (reg_read_in) begin
            if (reg_addr_in == ADDR_CONTROL_ZERO) begin
                rdata_d = {5'h0, suspend_q, trig_sel_q, start_q};
            end else if (reg_addr_in == ADDR_CONTROL_ONE) begin
                rdata_d = {7'h0, power_q};
            end else if (reg_addr_in == ADDR_STATUS) begin
                rdata_d = {5'h0, meas_state_q};
            end else if (reg_addr_in == ADDR_SENSE) begin
                rdata_d = {5'h0, stop_level, trig_level, supply_q};
            end
        end
    end

    // All state except the reset and input synchronisers registered here.
    always_ff @(posedge core_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            start_q <= CONTROL_ZERO_RESET[START_POS];
            trig_sel_q <= CONTROL_ZERO_RESET[TRIG_SEL_POS];
            suspend_q <= CONTROL_ZERO_RESET[SUSPEND_POS];
            power_q <= CONTROL_ONE_RESET[POWER_POS];
            meas_state_q <= STATUS_RESET[2:0];
            count_q <= 6'h0;
            state_q <= ST_STOPPED;
            rdata_q <= 8'h00;
            supply_q <= 1'b0;
            charge_q <= 1'b0;
            clkreq_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            start_q <= start_d;
            trig_sel_q <= trig_sel_d;
            suspend_q <= suspend_d;
            power_q <= power_d;
            meas_state_q <= meas_state_d;
            count_q <= count_d;
            state_q <= state_d;
            rdata_q <= rdata_d;
            supply_q <= supply_d;
            charge_q <= charge_d;
            clkreq_q <= clkreq_d;
            done_q <= done_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign measurement_supply_out = supply_q;
    assign filter_charge_out = charge_q;
    assign clock_request_out = clkreq_q;
    assign measure_done_out = done_q;
    assign unit_state_out = state_q;

    // Checks on the state machine and its pin outputs.
    a_supply_off_susp: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (state_q == ST_SUSP_TRIG || state_q == ST_SW_SUSP || state_q == ST_PREP_TRIG) |-> !measurement_supply_out)
        else $error("Supply on while suspended.");
    a_status_measure: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (state_q == ST_MEASURE) |-> (meas_state_q != 3'h0))
        else $error("Status zero while measuring.");
    a_status_wait: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (state_q == ST_SUSP_TRIG) |-> (meas_state_q == 3'h0))
        else $error("Status nonzero while awaiting trigger.");
    a_trig_wakes: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (state_q == ST_SUSP_TRIG && trig_rise && start_q && !wr_zero) |=> (state_q == ST_MEASURE))
        else $error("Trigger edge did not start measurement.");
    a_sw_done_clear: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (measuring && count_q == MEASURE_LAST && !trig_sel_q && !wr_zero) |=> !start_q)
        else $error("Start not cleared at completion.");
    a_ext_rearm: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (measuring && count_q == MEASURE_LAST && trig_sel_q && !wr_zero) |=> (start_q && state_q == ST_SUSP_TRIG))
        else $error("External trigger not rearmed.");
    a_force_stop: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (init_write && !start_write) |=> (!start_q && state_q != ST_MEASURE && meas_state_q == 3'h0))
        else $error("Forced stop did not halt.");
    a_start_stopped: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        !start_q |-> (state_q != ST_MEASURE && state_q != ST_SUSP_TRIG))
        else $error("Running with start clear.");
    a_sw_suspend: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (power_q && suspend_q && !trig_sel_q && !start_q && !$past(wr_zero)) |-> (state_q == ST_SW_SUSP))
        else $error("Software suspend not entered.");
    a_clk_request: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (state_q == ST_MEASURE && stop_level) |=> (clock_request_out || state_q != ST_MEASURE))
        else $error("No clock request in STOP.");
    // Further checks on supply, restart, prohibited settings and pulses.
    a_charge_follows: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        filter_charge_out == measurement_supply_out)
        else $error("Filter charge differs from supply.");
    a_start_ignored: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (measuring && start_write && !init_write && count_q != MEASURE_LAST && reg_wdata_in[TRIG_SEL_POS] == trig_sel_q
            && reg_wdata_in[SUSPEND_POS] == suspend_q) |=> (state_q == ST_MEASURE && start_q))
        else $error("Repeated start disturbed measurement.");
    a_prohibited_stop: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (power_q && start_q && (suspend_q != trig_sel_q)) |-> (state_q == ST_STOPPED))
        else $error("Prohibited setting did not stop.");
    a_supply_measure: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (state_q == ST_MEASURE) |-> (measurement_supply_out && filter_charge_out))
        else $error("Supply off while measuring.");
    a_wait_supply: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        (state_q == ST_WAIT_START) |-> measurement_supply_out)
        else $error("Supply off while waiting for start.");
    a_done_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_b)
        measure_done_out |=> !measure_done_out)
        else $error("Done pulse longer than one cycle.");

    // Cover points for the main scenarios.
    c_ext_measure: cover property (@(posedge core_clk_in) disable iff (!rst_b)
        state_q == ST_SUSP_TRIG ##1 state_q == ST_MEASURE);
    c_sw_measure: cover property (@(posedge core_clk_in) disable iff (!rst_b)
        state_q == ST_WAIT_START ##1 state_q == ST_MEASURE);
    c_stop_wake: cover property (@(posedge core_clk_in) disable iff (!rst_b)
        clock_request_out);
    c_forced_stop: cover property (@(posedge core_clk_in) disable iff (!rst_b)
        state_q == ST_MEASURE ##1 state_q == ST_STOPPED);
endmodule // touch_measure_state_control
`default_nettype wire

// ==== logic/touch_sync_edge.sv ====
/*
 Three-flop input synchroniser with rising-edge detect.
 Assumes the input is asynchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_sync_edge (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic level_q;
    logic level_d;
    logic rise_q;
    logic rise_d;
    // The change counts only once stages two and three agree.
    always_comb begin
        sync_d = {sync_q[1:0], async_in};
        level_d = level_q;
        if (sync_q[2] == sync_q[1]) begin
            level_d = sync_q[2];
        end
        rise_d = level_d & ~level_q;
    end
    // Registered stage; the first flop feeds only the second.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            level_q <= level_d;
            rise_q <= rise_d;
        end
    end
    assign level_out = level_q;
    assign rise_out = rise_q;
endmodule // touch_sync_edge
`default_nettype wire

// ==== sim/test_touch_measure_state_control.sv ====
/*
 Self-checking bench for the touch measurement state control block.
 Assumes the package constants and the far-side model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_touch_measure_state_control;
    import touch_ctrl_pkg::*;
    logic core_clk_in, rst_b_in, reg_write_in, reg_read_in, trig, stop;
    logic [3:0] reg_addr_in, ra;
    logic [7:0] reg_wdata_in, reg_rdata_out, rd;
    logic [31:0] r;
    logic measurement_supply_out, filter_charge_out, clock_request_out, measure_done_out;
    unit_state_t unit_state_out;
    int fail_count = 0, samples_checked = 0, cyc = 0, done_cyc = 0, t0 = 0, t1 = 0, seed = 32'h267995e6;
    touch_measure_state_control u_touch_measure_state_control (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .interval_trigger_in(trig), .cpu_stop_in(stop),
        .reg_rdata_out(reg_rdata_out), .measurement_supply_out(measurement_supply_out),
        .filter_charge_out(filter_charge_out), .clock_request_out(clock_request_out),
        .measure_done_out(measure_done_out), .unit_state_out(unit_state_out));
    touch_far_side u_touch_far_side (.core_clk_in(core_clk_in), .supply_in(measurement_supply_out),
        .filter_charge_in(filter_charge_out), .trigger_out(trig), .stop_out(stop));
    // Free-running clock at 100 MHz.
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    // Cycle counter and the cycle at which the last end-of-measurement pulse was seen.
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (measure_done_out === 1'b1) done_cyc <= cyc;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Strobes are raised just after an edge and dropped after the edge that takes them.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        t0 = cyc;
        reg_write_in <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge core_clk_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        #1 rd = reg_rdata_out;
    endtask
    // Reference model of the operating state for power and the three control bits.
    function automatic unit_state_t exp_state(input logic pon, input logic [2:0] c);
        if (!pon) return ST_STOPPED;
        case (c)
            3'b000: return ST_WAIT_START;
            3'b001: return ST_MEASURE;
            3'b110: return ST_PREP_TRIG;
            3'b111: return ST_SUSP_TRIG;
            3'b100: return ST_SW_SUSP;
            default: return ST_STOPPED;
        endcase
    endfunction
    // Supply and capacitor charge are on only while waiting for start or measuring.
    task automatic outs(input int n, input unit_state_t s);
        repeat (n) @(posedge core_clk_in);
        #1 check({5'h0, unit_state_out}, {5'h0, s});
        check({7'h0, measurement_supply_out}, {7'h0, s == ST_WAIT_START || s == ST_MEASURE});
        check({7'h0, filter_charge_out}, {7'h0, s == ST_WAIT_START || s == ST_MEASURE});
    endtask
    task automatic wait_done(input int from);
        for (int k = 0; k < 200 && done_cyc <= from; k++) @(posedge core_clk_in);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        print_verdict();
    end
    initial begin
        {rst_b_in, reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in} = '0;
        repeat (16) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        // Random writes to unmapped places that must change nothing, each followed by a reset-value read.
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            ra = 4'(4 + (r[7:0] % 12));
            wr(ra, r[15:8]);
            rdr(ra);
            check(rd, 8'h00);
            rdr(4'(i));
            check(rd, 8'h00);
        end
        $display("reset and unmapped test done");
        // Every control combination with power off and on, except start alone with power on, each from a forced stop.
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                if (p == 1 && c == 1) continue;
                wr(ADDR_CONTROL_ONE, 8'(p));
                wr(ADDR_CONTROL_ZERO, 8'h10);
                wr(ADDR_CONTROL_ZERO, 8'(c));
                outs(2, exp_state(p[0], c[2:0]));
                rdr(ADDR_CONTROL_ZERO);
                check(rd, 8'(c));
            end
        end
        $display("state table test done");
        // Software measurement with a second start write landing mid-way.
        wr(ADDR_CONTROL_ZERO, 8'h10);
        wr(ADDR_CONTROL_ZERO, 8'h01);
        t1 = t0;
        outs(0, ST_MEASURE);
        rdr(ADDR_STATUS);
        check(rd, {5'h0, STATE_CHARGE_CODE});
        wr(ADDR_CONTROL_ZERO, 8'h01);
        repeat (10) @(posedge core_clk_in);
        rdr(ADDR_STATUS);
        check(rd, {5'h0, STATE_COUNT_CODE});
        wait_done(t1);
        // The registered pulse is seen one edge after the last count.
        check(8'(done_cyc - t1), 8'(MEASURE_CYCLES + 1));
        outs(0, ST_WAIT_START);
        rdr(ADDR_CONTROL_ZERO);
        check(rd, 8'h00);
        $display("software measurement test done");
        // External trigger, first with the CPU stopped, then running, then a forced stop.
        wr(ADDR_CONTROL_ZERO, 8'h07);
        outs(2, ST_SUSP_TRIG);
        rdr(ADDR_STATUS);
        check(rd, 8'h00);
        for (int n = 0; n < 3; n++) begin
            t1 = cyc;
            u_touch_far_side.fire(n == 0);
            outs(0, ST_MEASURE);
            check({7'h0, clock_request_out}, {7'h0, n == 0});
            rdr(ADDR_STATUS);
            check({7'h0, rd[2:0] != 3'h0}, 8'h01);
            if (n == 2) break;
            wait_done(t1);
            outs(1, ST_SUSP_TRIG);
            rdr(ADDR_CONTROL_ZERO);
            check(rd, 8'h07);
        end
        wr(ADDR_CONTROL_ZERO, 8'h16);
        t1 = t0;
        repeat (40) @(posedge core_clk_in);
        check({7'h0, unit_state_out == ST_MEASURE || done_cyc > t1}, 8'h00);
        rdr(ADDR_STATUS);
        check(rd, 8'h00);
        $display("external trigger test done");
        // Software suspend, a trigger that must be ignored, the settle wait and the return.
        wr(ADDR_CONTROL_ZERO, 8'h04);
        outs(2, ST_SW_SUSP);
        u_touch_far_side.fire(1'b1);
        outs(6, ST_SW_SUSP);
        rdr(ADDR_SENSE);
        check(rd, 8'h04);
        check(8'(u_touch_far_side.cap_level), 8'h00);
        wr(ADDR_CONTROL_ZERO, 8'h00);
        repeat (SNZ_SETTLE_BASE_CYCLES) @(posedge core_clk_in);
        wr(ADDR_CONTROL_ZERO, 8'h01);
        t1 = t0;
        wait_done(t1);
        outs(0, ST_WAIT_START);
        wr(ADDR_CONTROL_ZERO, 8'h04);
        outs(2, ST_SW_SUSP);
        $display("software suspend test done");
        // Reset in the middle of a measurement clears status and control.
        wr(ADDR_CONTROL_ZERO, 8'h00);
        repeat (SNZ_SETTLE_BASE_CYCLES) @(posedge core_clk_in);
        wr(ADDR_CONTROL_ZERO, 8'h01);
        repeat (5) @(posedge core_clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        outs(3, ST_STOPPED);
        rdr(ADDR_STATUS);
        check(rd, 8'h00);
        rdr(ADDR_CONTROL_ONE);
        check(rd, 8'h00);
        $display("mid-run reset test done");
        print_verdict();
    end
endmodule // test_touch_measure_state_control
`default_nettype wire

// ==== sim/touch_far_side.sv ====
/*
 Far-side model: interval timer trigger, CPU stop level and the filter capacitor.
 Assumes the core clock and the unit's supply and charge outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_far_side (
    input wire logic core_clk_in,
    input wire logic supply_in,
    input wire logic filter_charge_in,
    output var logic trigger_out,
    output var logic stop_out
);
    int cap_level = 0;
    // The capacitor holds charge only while driven, so a suspended unit lets it leak away.
    always @(posedge core_clk_in) begin
        if (filter_charge_in && supply_in) cap_level <= 8;
        else if (cap_level > 0) cap_level <= cap_level - 1;
    end
    // The timer output idles low and the CPU starts out running.
    initial begin
        trigger_out = 1'b0;
        stop_out = 1'b0;
    end
    // The pulse is held six cycles so that it survives the three-flop synchroniser.
    task automatic fire(input logic in_stop);
        stop_out <= in_stop;
        repeat (2) @(posedge core_clk_in);
        trigger_out <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        trigger_out <= 1'b0;
    endtask
endmodule // touch_far_side
`default_nettype wire
